// ### include/chdtc_pkg.sv
/*
 * chdtc_pkg: constants and types for the card host data transfer control block.
 * assumes a 32-bit axi4-lite register bus; register indices are printed values,
 * byte address is four times the index.
 */
package chdtc_pkg;
   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam logic [19:0] CHDTC_IDX_CMD = 20'h0_0064;
   localparam logic [19:0] CHDTC_IDX_STATUS = 20'h0_006e;
   localparam logic [19:0] CHDTC_IDX_MEMTEST = 20'h3_0ffc;
   localparam logic [19:0] CHDTC_IDX_BUFDEF = 20'h0_0070;
   localparam logic [19:0] CHDTC_IDX_LENGTH = 20'h0_0071;
   localparam logic [19:0] CHDTC_IDX_NOTIFY = 20'h0_0072;
   localparam logic [19:0] CHDTC_IDX_MODE = 20'h0_0073;
   localparam logic [19:0] CHDTC_IDX_INVAL = 20'h0_0074;
   localparam int CHDTC_AW = 22;
   localparam logic [21:0] CHDTC_A_CMD = {CHDTC_IDX_CMD, 2'b00};
   localparam logic [21:0] CHDTC_A_STATUS = {CHDTC_IDX_STATUS, 2'b00};
   localparam logic [21:0] CHDTC_A_MEMTEST = {CHDTC_IDX_MEMTEST, 2'b00};
   localparam logic [21:0] CHDTC_A_BUFDEF = {CHDTC_IDX_BUFDEF, 2'b00};
   localparam logic [21:0] CHDTC_A_LENGTH = {CHDTC_IDX_LENGTH, 2'b00};
   localparam logic [21:0] CHDTC_A_NOTIFY = {CHDTC_IDX_NOTIFY, 2'b00};
   localparam logic [21:0] CHDTC_A_MODE = {CHDTC_IDX_MODE, 2'b00};
   localparam logic [21:0] CHDTC_A_INVAL = {CHDTC_IDX_INVAL, 2'b00};
   // ****************************************************************
   // command and status bits
   // ****************************************************************
   localparam int CHDTC_CMD_START_BIT = 16;
   localparam int CHDTC_CMD_WAIT_BIT = 17;
   localparam int CHDTC_CMD_ABORT_BIT = 18;
   localparam int CHDTC_ST_BLOCK_BIT = 8;
   localparam int CHDTC_ST_END_BIT = 9;
   localparam int CHDTC_ST_FLOW_BIT = 10;
   localparam int CHDTC_ST_FAULT_BIT = 11;
   localparam int CHDTC_ST_BUSY_BIT = 12;
   localparam int CHDTC_ST_WAIT_BIT = 13;
   localparam int CHDTC_ST_VALID_BIT = 14;
   localparam int CHDTC_ST_REFUSE_BIT = 15;
   // ****************************************************************
   // buffer kinds, directions, modes, granularity, reset values
   // ****************************************************************
   localparam logic [15:0] CHDTC_BUF_SAMPLE = 16'h03e8;
   localparam logic [15:0] CHDTC_BUF_SLOW = 16'h07d0;
   localparam logic [15:0] CHDTC_BUF_STAMP = 16'h0bb8;
   localparam logic CHDTC_DIR_TO_CARD = 1'b0;
   localparam logic CHDTC_DIR_TO_HOST = 1'b1;
   localparam logic CHDTC_MODE_ACQ = 1'b0;
   localparam logic CHDTC_MODE_REPLAY = 1'b1;
   localparam int CHDTC_GRAN_SHIFT = 6;
   localparam logic [31:0] CHDTC_ZERO32 = 32'h0000_0000;
   localparam logic [1:0] CHDTC_RESP_OKAY = 2'b00;
   localparam logic [1:0] CHDTC_RESP_SLVERR = 2'b10;
   localparam logic [1:0] CHDTC_RESP_DECERR = 2'b11;
   // buffer definition as written by software
   typedef struct packed {
      logic [15:0] kind;   // buffer_kind code
      logic dir;           // transfer direction
      logic valid;         // buffer defined and not invalidated
   } chdtc_buf_s;
   // transfer engine states
   typedef enum logic [1:0] {CHDTC_IDLE, CHDTC_ARMED, CHDTC_RUN} chdtc_state_e;
endpackage

// ### core/chdtc_top.sv
/*
 * chdtc_top: command, status and memory-test control of host data transfers.
 * assumes a data mover beside it that moves bytes and reports them with
 * mover_beat; trigger, flow and fault inputs come from other logic on aclk.
 */
// Implementation choice: register access over AXI4-Lite.
// Functional notes
// - writing one enters test mode, commands ignored; here only card command bits are dropped, transfer commands still run
// - writing zero leaves test mode, commands resume
// - test mode allows transfers in either direction
// - buffer invalidated on redefine, completion, request
// - one register carries card and transfer commands
// - command register write-only, executes set bits
// - start transfer, held until trigger in acquisition; here test mode skips the trigger hold and runs at once
// - wait blocks until end or block available; here also released after WAIT_TIMEOUT cycles
// - abort stops transfer, data marked invalid
// - status register read-only, shows current flags
// - block flag when notify bytes are available
// - end flag only when notify size zero
// - flow flag on overrun or underrun
// - internal fault flag on engine error
// - notify zero events at end, else each block
// - wrong-direction transfers refused outside test mode
module chdtc_top
   import chdtc_pkg::*;
#(
   parameter int LEN_W = 32,           // transfer length counter width
   parameter int WAIT_TIMEOUT = 100000 // wait command timeout in cycles
) (
   input wire logic aclk,                    // bus clock, 20 MHz
   input wire logic aresetn,                 // synchronous reset, active low
   input wire logic [CHDTC_AW-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid,           // write address valid
   output logic s_axi_awready,               // write address ready
   input wire logic [31:0] s_axi_wdata,      // write data
   input wire logic [3:0] s_axi_wstrb,       // write byte strobes
   input wire logic s_axi_wvalid,            // write data valid
   output logic s_axi_wready,                // write data ready
   output logic [1:0] s_axi_bresp,           // write response
   output logic s_axi_bvalid,                // write response valid
   input wire logic s_axi_bready,            // write response ready
   input wire logic [CHDTC_AW-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid,           // read address valid
   output logic s_axi_arready,               // read address ready
   output logic [31:0] s_axi_rdata,          // read data
   output logic [1:0] s_axi_rresp,           // read response
   output logic s_axi_rvalid,                // read data valid
   input wire logic s_axi_rready,            // read data ready
   input wire logic trigger_seen,            // card has received its trigger
   input wire logic mover_beat,              // mover moved 64 bytes this cycle
   input wire logic flow_fault,              // overrun or underrun pulse
   input wire logic internal_fault,          // internal engine fault pulse
   output logic mover_run,                   // mover may move data
   output logic mover_dir,                   // 1 card to host, 0 host to card
   output logic memory_test_mode,            // test mode active
   output logic [15:0] card_cmd              // card control command pulse bits
);
   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   initial begin
      if (LEN_W < 8 || LEN_W > 32) $error("LEN_W out of range");
      if (WAIT_TIMEOUT < 1) $error("WAIT_TIMEOUT must be positive");
   end

   // ****************************************************************
   // bus slave: write path
   // ****************************************************************
   logic aw_held_r, w_held_r;
   logic [CHDTC_AW-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go, wait_busy_r, wait_done, do_wait, do_abort;
   // the response is held back while a wait command blocks
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid && !wait_busy_r;

   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= CHDTC_ZERO32;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // ready only while the holding slot is empty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // write decode
   logic wr_cmd, wr_memtest, wr_bufdef, wr_len, wr_notify, wr_mode, wr_inval, wr_hit, full_word;
   assign full_word = (wstrb_r == 4'hf);
   assign wr_cmd = wr_go && awaddr_r == CHDTC_A_CMD && full_word;
   assign wr_memtest = wr_go && awaddr_r == CHDTC_A_MEMTEST && full_word;
   assign wr_bufdef = wr_go && awaddr_r == CHDTC_A_BUFDEF && full_word;
   assign wr_len = wr_go && awaddr_r == CHDTC_A_LENGTH && full_word;
   assign wr_notify = wr_go && awaddr_r == CHDTC_A_NOTIFY && full_word;
   assign wr_mode = wr_go && awaddr_r == CHDTC_A_MODE && full_word;
   assign wr_inval = wr_go && awaddr_r == CHDTC_A_INVAL && full_word;
   assign wr_hit = wr_cmd | wr_memtest | wr_bufdef | wr_len | wr_notify | wr_mode | wr_inval;

   // response: slverr for partial strobes, decerr for unmapped
   logic addr_known;
   assign addr_known = awaddr_r == CHDTC_A_CMD || awaddr_r == CHDTC_A_MEMTEST
      || awaddr_r == CHDTC_A_BUFDEF || awaddr_r == CHDTC_A_LENGTH || awaddr_r == CHDTC_A_NOTIFY
      || awaddr_r == CHDTC_A_MODE || awaddr_r == CHDTC_A_INVAL || awaddr_r == CHDTC_A_STATUS;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CHDTC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= !(do_wait && !do_abort);  // a wait answers later
         if (!addr_known) s_axi_bresp <= CHDTC_RESP_DECERR;
         else if (!wr_hit) s_axi_bresp <= CHDTC_RESP_SLVERR;  // status is read-only
         else s_axi_bresp <= CHDTC_RESP_OKAY;
      end else if (wait_done) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   chdtc_buf_s buf_r;
   logic [LEN_W-1:0] len_r, notify_r;
   logic mode_r, refuse_r, data_valid_r;
   chdtc_state_e state_r;
   logic [LEN_W-1:0] moved_r, since_r;
   logic done_evt;
   localparam logic [LEN_W-1:0] LEN_ZERO = '0;
   localparam logic [LEN_W-1:0] BEAT_BYTES = LEN_W'(64);

   // test mode flag
   always_ff @(posedge aclk) begin
      if (!aresetn) memory_test_mode <= 1'b0;
      else if (wr_memtest) memory_test_mode <= wdata_r[0];  // one enters zero leaves
   end

   // length, notify size and operating mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         len_r <= LEN_ZERO;
         notify_r <= LEN_ZERO;
         mode_r <= CHDTC_MODE_ACQ;
      end else begin
         // low six bits dropped: hardware counts whole 64-byte beats only
         if (wr_len) len_r <= {wdata_r[LEN_W-1:CHDTC_GRAN_SHIFT], 6'b00_0000};
         if (wr_notify) notify_r <= wdata_r[LEN_W-1:0];
         if (wr_mode) mode_r <= wdata_r[0];
      end
   end

   // buffer definition and invalidation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buf_r <= '0;
      end else if (wr_bufdef) begin
         // a new definition replaces and so invalidates the old one
         buf_r.kind <= wdata_r[15:0];
         buf_r.dir <= wdata_r[16];
         buf_r.valid <= 1'b1;
      end else if (done_evt) begin
         buf_r.valid <= 1'b0;
      end else if (wr_inval && wdata_r[15:0] == buf_r.kind) begin
         buf_r.valid <= 1'b0;                                   // kind must match
      end
   end

   // ****************************************************************
   // command decode
   // ****************************************************************
   logic cmd_ok, do_start, dir_ok;
   // card commands are dropped while test mode is on
   assign cmd_ok = wr_cmd && !memory_test_mode;
   // direction against mode is refused unless in test mode
   assign dir_ok = memory_test_mode || (mode_r == CHDTC_MODE_ACQ ? buf_r.dir == CHDTC_DIR_TO_HOST
                                                                 : buf_r.dir == CHDTC_DIR_TO_CARD);
   // start only accepted with a valid buffer and nothing running
   assign do_start = wr_cmd && wdata_r[CHDTC_CMD_START_BIT] && buf_r.valid && state_r == CHDTC_IDLE && dir_ok;
   assign do_abort = wr_cmd && wdata_r[CHDTC_CMD_ABORT_BIT];
   assign do_wait = wr_cmd && wdata_r[CHDTC_CMD_WAIT_BIT];

   // card control bits pass on in the same write
   always_ff @(posedge aclk) begin
      if (!aresetn) card_cmd <= 16'h0000;
      else card_cmd <= cmd_ok ? wdata_r[15:0] : 16'h0000;
   end

   // refused start remembered for software
   always_ff @(posedge aclk) begin
      if (!aresetn) refuse_r <= 1'b0;
      else if (wr_cmd && wdata_r[CHDTC_CMD_START_BIT] && buf_r.valid && !dir_ok) refuse_r <= 1'b1;
      else if (do_start) refuse_r <= 1'b0;
   end

   // ****************************************************************
   // transfer engine
   // ****************************************************************
   logic at_end, at_block;
   assign at_end = (moved_r + BEAT_BYTES) >= len_r;
   assign at_block = notify_r != LEN_ZERO && (since_r + BEAT_BYTES) >= notify_r;
   assign done_evt = state_r == CHDTC_RUN && mover_beat && at_end;

   // state: abort wins over start in the same write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= CHDTC_IDLE;
      end else begin
         case (state_r)
            CHDTC_IDLE: begin
               if (do_start && !do_abort) begin
                  // acquisition waits for the trigger unless in test mode
                  if (mode_r == CHDTC_MODE_ACQ && !memory_test_mode && !trigger_seen) state_r <= CHDTC_ARMED;
                  else state_r <= CHDTC_RUN;
               end
            end
            CHDTC_ARMED: begin
               if (do_abort) state_r <= CHDTC_IDLE;
               else if (trigger_seen) state_r <= CHDTC_RUN;
            end
            CHDTC_RUN: begin
               if (do_abort || done_evt) state_r <= CHDTC_IDLE;
            end
            default: state_r <= CHDTC_IDLE;
         endcase
      end
   end

   // byte counters in 64-byte beats
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         moved_r <= LEN_ZERO;
         since_r <= LEN_ZERO;
      end else if (do_start) begin
         moved_r <= LEN_ZERO;
         since_r <= LEN_ZERO;
      end else if (state_r == CHDTC_RUN && mover_beat) begin
         moved_r <= moved_r + BEAT_BYTES;
         since_r <= at_block ? LEN_ZERO : since_r + BEAT_BYTES;
      end
   end

   // mover controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mover_run <= 1'b0;
         mover_dir <= CHDTC_DIR_TO_CARD;
      end else begin
         mover_run <= state_r == CHDTC_RUN && !done_evt && !do_abort;
         mover_dir <= buf_r.dir;
      end
   end

   // ****************************************************************
   // status flags: hardware set wins over the start clear
   // ****************************************************************
   logic blk_r, end_r, flow_r, fault_r;
   logic beat_run;
   assign beat_run = state_r == CHDTC_RUN && mover_beat;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blk_r <= 1'b0;
         end_r <= 1'b0;
         flow_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         // block flag after each notify-size worth, stays set
         if (beat_run && at_block) blk_r <= 1'b1;
         else if (do_start) blk_r <= 1'b0;
         // end flag only with notify size zero
         if (done_evt && notify_r == LEN_ZERO) end_r <= 1'b1;
         else if (do_start) end_r <= 1'b0;
         if (flow_fault && state_r != CHDTC_IDLE) flow_r <= 1'b1;
         else if (do_start) flow_r <= 1'b0;
         if (internal_fault && state_r != CHDTC_IDLE) fault_r <= 1'b1;
         else if (do_start) fault_r <= 1'b0;
      end
   end

   // transferred data marked invalid on abort
   always_ff @(posedge aclk) begin
      if (!aresetn) data_valid_r <= 1'b0;
      else if (do_abort) data_valid_r <= 1'b0;
      else if (do_start) data_valid_r <= 1'b1;
   end

   // ****************************************************************
   // wait command: holds the write response
   // ****************************************************************
   logic [31:0] wait_cnt_r;
   logic wait_met;
   assign wait_met = state_r == CHDTC_IDLE || blk_r || end_r;
   assign wait_done = wait_busy_r && (wait_met || wait_cnt_r >= 32'(WAIT_TIMEOUT - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_busy_r <= 1'b0;
         wait_cnt_r <= CHDTC_ZERO32;
      end else if (do_wait && !do_abort) begin
         wait_busy_r <= 1'b1;
         wait_cnt_r <= CHDTC_ZERO32;
      end else if (wait_busy_r) begin
         // release when the engine is idle, on the block or end flag, or on timeout
         if (wait_done) wait_busy_r <= 1'b0;
         wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
      end
   end

   // ****************************************************************
   // bus slave: read path
   // ****************************************************************
   logic [31:0] status_word;
   always_comb begin
      status_word = CHDTC_ZERO32;
      status_word[CHDTC_ST_BLOCK_BIT] = blk_r;
      status_word[CHDTC_ST_END_BIT] = end_r;
      status_word[CHDTC_ST_FLOW_BIT] = flow_r;
      status_word[CHDTC_ST_FAULT_BIT] = fault_r;
      status_word[CHDTC_ST_BUSY_BIT] = state_r != CHDTC_IDLE;
      status_word[CHDTC_ST_WAIT_BIT] = state_r == CHDTC_ARMED;
      status_word[CHDTC_ST_VALID_BIT] = data_valid_r;
      status_word[CHDTC_ST_REFUSE_BIT] = refuse_r;
   end

   // one-word read, answered the cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= CHDTC_ZERO32;
         s_axi_rresp <= CHDTC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CHDTC_RESP_OKAY;
            case (s_axi_araddr)
               CHDTC_A_STATUS: s_axi_rdata <= status_word;                 // live flags
               CHDTC_A_MEMTEST: s_axi_rdata <= {31'h0000_0000, memory_test_mode};
               CHDTC_A_BUFDEF: s_axi_rdata <= {14'h0000, buf_r.valid, buf_r.dir, buf_r.kind};
               CHDTC_A_LENGTH: s_axi_rdata <= 32'(len_r);
               CHDTC_A_NOTIFY: s_axi_rdata <= 32'(notify_r);
               CHDTC_A_MODE: s_axi_rdata <= {31'h0000_0000, mode_r};
               CHDTC_A_CMD, CHDTC_A_INVAL: begin
                  s_axi_rdata <= CHDTC_ZERO32;                             // write-only
                  s_axi_rresp <= CHDTC_RESP_SLVERR;
               end
               default: begin
                  s_axi_rdata <= CHDTC_ZERO32;
                  s_axi_rresp <= CHDTC_RESP_DECERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ### test/chdtc_mover_model.sv
/* chdtc_mover_model: stand-in for the data mover beside the block.
   assumes the aclk domain; slow makes it stall like a busy host path. */
module chdtc_mover_model (
   input wire logic aclk, // bus clock
   input wire logic mover_run, // moving permitted
   input wire logic slow, // one beat per eight cycles
   output logic mover_beat // 64 bytes moved
);
   logic [2:0] gap_r;
   // beats one cycle behind mover_run, so one beat can follow its fall; never early, however slow the path
   always_ff @(posedge aclk) begin
      gap_r <= mover_run ? gap_r + 3'h1 : 3'h0;
      mover_beat <= mover_run && (!slow || gap_r == 3'h7);
   end
endmodule

// ### test/chdtc_assertions.sv
/* chdtc_assertions: port checks of chdtc_top.
   assumes it is bound to the top module; one clock, sync reset. */
module chdtc_assertions
   import chdtc_pkg::*;
(
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low active
   input wire logic [CHDTC_AW-1:0] s_axi_awaddr, // write addr
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // strobes
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // write resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic [CHDTC_AW-1:0] s_axi_araddr, // read addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic mover_run, // mover enable
   input wire logic memory_test_mode, // test mode
   input wire logic [15:0] card_cmd // card pulses
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic wr_take;
   // full-word write with both channels taken at once, as the bench offers
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && (s_axi_wstrb == 4'hf);
   chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_status_ro: assert property (wr_take && s_axi_awaddr == CHDTC_A_STATUS
      |-> ##2 s_axi_bvalid && s_axi_bresp == CHDTC_RESP_SLVERR) else $error("status write accepted");
   chk_cmd_write_only: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CHDTC_A_CMD
      |=> s_axi_rresp == CHDTC_RESP_SLVERR && s_axi_rdata == CHDTC_ZERO32) else $error("cmd readable");
   chk_card_pulse: assert property (card_cmd != 16'h0000 |=> card_cmd == 16'h0000)
      else $error("card pulse too long");
   chk_test_quiet: assert property (memory_test_mode |-> card_cmd == 16'h0000)
      else $error("card command in test mode");
   chk_abort_stops: assert property (wr_take && s_axi_awaddr == CHDTC_A_CMD && !memory_test_mode
      && s_axi_wdata[CHDTC_CMD_ABORT_BIT] |-> ##[1:3] !mover_run) else $error("abort ignored");
   chk_test_enter: assert property (wr_take && s_axi_awaddr == CHDTC_A_MEMTEST && s_axi_wdata == 32'h0000_0001
      |-> ##[1:2] memory_test_mode) else $error("test mode not entered");
   chk_test_leave: assert property (wr_take && s_axi_awaddr == CHDTC_A_MEMTEST && s_axi_wdata == CHDTC_ZERO32
      |-> ##[1:2] !memory_test_mode) else $error("test mode not left");
   cov_run: cover property ($rose(mover_run));
   cov_card: cover property (card_cmd != 16'h0000);
   cov_test: cover property ($rose(memory_test_mode));
endmodule

// ### test/tb_card_host_data_transfer_control.sv
/* tb_card_host_data_transfer_control: directed bench for chdtc_top.
   assumes the mover model beside it; wait timeout shortened to 20. */
module tb_card_host_data_transfer_control;
   import chdtc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %h got %h", nm, e, a); end end
   logic aclk, aresetn, awv, wv, arv, trig, slow, flt, ifl, beat, run;
   logic [21:0] awa, ara;
   logic [31:0] wd, rdat, d;
   logic [1:0] bresp, rresp, r;
   logic awr, wr_rdy, bv, arr, rv;
   int n_mismatch = 0;
   int samples_checked = 0;
   chdtc_top #(.WAIT_TIMEOUT(20)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
      .trigger_seen(trig), .mover_beat(beat), .flow_fault(flt), .internal_fault(ifl), .mover_run(run),
      .mover_dir(), .memory_test_mode(), .card_cmd());
   chdtc_mover_model mover (.aclk(aclk), .mover_run(run), .slow(slow), .mover_beat(beat));
   // ****************************************************************
   // bus tasks and verdict
   // ****************************************************************
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // each channel is released on the edge that takes it; a hung answer ends the run
   task automatic wr(input logic [21:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end while (!bv && n < 100);
      rs = bresp;
      if (n >= 100) begin n_mismatch++; wrap_up(); end
   endtask
   task automatic rd(input logic [21:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      ara <= a;
      arv <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arr) arv <= 1'b0;
      end while (!rv && n < 100);
      v = rdat;
      rs = rresp;
      if (n >= 100) begin n_mismatch++; wrap_up(); end
   endtask
   task automatic s_regs();
      wr(CHDTC_A_STATUS, 32'h0000_0001, r); `CHK("status write", CHDTC_RESP_SLVERR, r)
      rd(22'h00_0000, d, r); `CHK("unmapped", CHDTC_RESP_DECERR, r)
      rd(CHDTC_A_CMD, d, r); `CHK("cmd read", CHDTC_RESP_SLVERR, r)
   endtask
   task automatic s_memtest();
      wr(CHDTC_A_MEMTEST, 32'h0000_0001, r);
      rd(CHDTC_A_MEMTEST, d, r); `CHK("test on", 32'h0000_0001, d)
      wr(CHDTC_A_CMD, 32'h0003_0005, r); `CHK("ignored cmd", CHDTC_RESP_OKAY, r)
      rd(CHDTC_A_STATUS, d, r); `CHK("test dir", CHDTC_ZERO32, d & 32'h0000_9000)
      wr(CHDTC_A_MEMTEST, CHDTC_ZERO32, r);
      rd(CHDTC_A_MEMTEST, d, r); `CHK("test off", CHDTC_ZERO32, d)
   endtask
   task automatic s_full();
      wr(CHDTC_A_MODE, CHDTC_ZERO32, r);
      wr(CHDTC_A_BUFDEF, 32'h0001_03e8, r);
      wr(CHDTC_A_LENGTH, 32'h0000_0100, r);
      wr(CHDTC_A_NOTIFY, CHDTC_ZERO32, r);
      wr(CHDTC_A_CMD, 32'h0003_0002, r);
      rd(CHDTC_A_STATUS, d, r); `CHK("end only", 32'h0000_0200, d & 32'h0000_1200)
      rd(CHDTC_A_BUFDEF, d, r); `CHK("buf spent", 1'b0, d[17])
   endtask
   task automatic s_refuse();
      wr(CHDTC_A_BUFDEF, 32'h0000_03e8, r);
      wr(CHDTC_A_CMD, 32'h0001_0000, r);
      rd(CHDTC_A_STATUS, d, r); `CHK("refused", 32'h0000_8000, d & 32'h0000_9000)
   endtask
   task automatic s_block();
      slow <= 1'b1;
      trig <= 1'b0;
      wr(CHDTC_A_BUFDEF, 32'h0001_07d0, r);
      wr(CHDTC_A_LENGTH, 32'h0000_0200, r);
      wr(CHDTC_A_NOTIFY, 32'h0000_0080, r);
      wr(CHDTC_A_CMD, 32'h0001_0000, r);
      rd(CHDTC_A_STATUS, d, r); `CHK("armed", 1'b1, d[13])
      trig <= 1'b1;
      wr(CHDTC_A_CMD, 32'h0002_0000, r);
      rd(CHDTC_A_STATUS, d, r); `CHK("block", 32'h0000_1100, d & 32'h0000_1300)
      flt <= 1'b1;
      ifl <= 1'b1;
      @(posedge aclk);
      flt <= 1'b0;
      ifl <= 1'b0;
      rd(CHDTC_A_STATUS, d, r); `CHK("faults", 32'h0000_0c00, d & 32'h0000_0c00)
      wr(CHDTC_A_CMD, 32'h0004_0000, r);
      rd(CHDTC_A_STATUS, d, r); `CHK("aborted", CHDTC_ZERO32, d & 32'h0000_5000)
      wr(CHDTC_A_INVAL, 32'h0000_07d0, r);
      rd(CHDTC_A_BUFDEF, d, r); `CHK("invalidated", 1'b0, d[17])
   endtask
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // reset for 12 cycles, then the scenarios in order
   initial begin
      {aresetn, awv, wv, arv, trig, slow, flt, ifl} = 8'h08;
      {awa, ara, wd} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      s_regs();
      s_full();
      s_refuse();
      s_memtest();
      s_block();
      wrap_up();
   end
endmodule
bind chdtc_top chdtc_assertions u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .mover_run, .memory_test_mode, .card_cmd);
